// File: pkg/wcb_defs.svh
`ifndef WCB_DEFS_SVH
`define WCB_DEFS_SVH
// byte locations on the 8-bit data bus
`define WCB_LOC_COUNT_LO   4'h0
`define WCB_LOC_COUNT_HI   4'h1
`define WCB_LOC_CMPA_LO    4'h2
`define WCB_LOC_CMPA_HI    4'h3
`define WCB_LOC_CMPB_LO    4'h4
`define WCB_LOC_CMPB_HI    4'h5
`define WCB_LOC_CAP_LO     4'h6
`define WCB_LOC_CAP_HI     4'h7
`define WCB_LOC_CTRL_A     4'h8
`define WCB_LOC_CTRL_B     4'h9
// field positions
`define WCB_WAVE_LO_MSB    1
`define WCB_WAVE_LO_LSB    0
`define WCB_WAVE_HI_MSB    4
`define WCB_WAVE_HI_LSB    3
`define WCB_CSEL_MSB       2
`define WCB_CSEL_LSB       0
// reset values and fixed count ceilings
`define WCB_RST_BYTE       8'h00
`define WCB_RST_WORD       16'h0000
`define WCB_MAX            16'hFFFF
`define WCB_TOP_8BIT       16'h00FF
`define WCB_TOP_9BIT       16'h01FF
`define WCB_TOP_10BIT      16'h03FF
`endif

// File: pkg/wcb_pkg.sv
package wcb_pkg;
    typedef logic [15:0] wcb_word_t;
    typedef logic [7:0]  wcb_byte_t;
    typedef enum logic [0:0]
    {
        WCB_DIR_UP   = 1'b0,
        WCB_DIR_DOWN = 1'b1
    } wcb_dir_e;
    typedef struct packed
    {
        wcb_word_t   count;
        wcb_byte_t   temp;
        wcb_word_t   cmp_a;
        wcb_word_t   cmp_b;
        wcb_word_t   cap;
        wcb_byte_t   ctrl_a;
        wcb_byte_t   ctrl_b;
        wcb_dir_e    dir;
        logic        ovf;
        logic [9:0]  presc;
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_prev;
        wcb_byte_t   rdata;
    } wcb_state_s;
endpackage

// File: core/wcb_timer.sv
`timescale 1ns/100ps
`include "wcb_defs.svh"
module wcb_timer
    import wcb_pkg::*;
(
    // clock and reset
    input  wire logic        I_MCLK,
    input  wire logic        I_RST_N,
    // byte bus
    input  wire logic [3:0]  I_ADDR,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    input  wire logic [7:0]  I_WDATA,
    output logic      [7:0]  O_RDATA,
    // timer events
    input  wire logic        I_EXT_TICK,
    input  wire logic        I_CAPTURE,
    input  wire logic        I_OVF_CLR,
    output logic             O_OVF_FLAG,
    output logic             O_AT_TOP,
    output logic             O_AT_FLOOR,
    output logic      [15:0] O_COUNT
);
    // ************************************************************
    // ** decode
    // ************************************************************
    wcb_state_s s_q;
    wcb_state_s s_d;
    logic [3:0] wave;
    logic [2:0] csel;
    wcb_word_t  top;
    logic       tick;
    logic       dual_slope;
    logic       cap_is_top;
    logic       ctc_mode;
    logic       wr_cnt_lo;

    assign wave = {s_q.ctrl_b[`WCB_WAVE_HI_MSB:`WCB_WAVE_HI_LSB],
                   s_q.ctrl_a[`WCB_WAVE_LO_MSB:`WCB_WAVE_LO_LSB]};
    assign csel = s_q.ctrl_b[`WCB_CSEL_MSB:`WCB_CSEL_LSB];
    assign cap_is_top = (wave == 4'h8) || (wave == 4'hA) || (wave == 4'hC) || (wave == 4'hE);
    assign dual_slope = ((wave >= 4'h1) && (wave <= 4'h3)) || ((wave >= 4'h8) && (wave <= 4'hB));
    assign ctc_mode   = (wave == 4'h4) || (wave == 4'hC);
    assign wr_cnt_lo  = I_WR && (I_ADDR == `WCB_LOC_COUNT_LO);

    always_comb
    begin
        unique case (wave)
            4'h1, 4'h5: top = `WCB_TOP_8BIT;
            4'h2, 4'h6: top = `WCB_TOP_9BIT;
            4'h3, 4'h7: top = `WCB_TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top = s_q.cmp_a;
            4'h8, 4'hA, 4'hC, 4'hE: top = s_q.cap;
            default: top = `WCB_MAX;
        endcase
    end

    // tick source; the external input is edge-sampled, so it must stay below half MCLK
    always_comb
    begin
        unique case (csel)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = &s_q.presc[2:0];
            3'h3: tick = &s_q.presc[5:0];
            3'h4: tick = &s_q.presc[7:0];
            3'h5: tick = &s_q.presc[9:0];
            3'h6: tick = s_q.ext_prev & ~s_q.ext_s2;
            3'h7: tick = ~s_q.ext_prev & s_q.ext_s2;
        endcase
    end

    // ************************************************************
    // ** next state
    // ************************************************************
    always_comb
    begin
        s_d          = s_q;
        s_d.presc    = s_q.presc + 10'h001;
        s_d.ext_s1   = I_EXT_TICK;
        s_d.ext_s2   = s_q.ext_s1;
        s_d.ext_prev = s_q.ext_s2;
        if (I_OVF_CLR)
        begin
            s_d.ovf = 1'b0;
        end
        if (I_CAPTURE && !cap_is_top)
        begin
            s_d.cap = s_q.count;
        end
        if (tick)
        begin
            if (dual_slope)
            begin
                if (s_q.dir == WCB_DIR_UP)
                begin
                    if (s_q.count >= top)
                    begin
                        s_d.dir   = WCB_DIR_DOWN;
                        s_d.count = s_q.count - 16'h0001;
                    end
                    else
                    begin
                        s_d.count = s_q.count + 16'h0001;
                    end
                end
                else if (s_q.count == `WCB_RST_WORD)
                begin
                    s_d.dir   = WCB_DIR_UP;
                    s_d.count = 16'h0001;
                    s_d.ovf   = 1'b1;
                end
                else
                begin
                    s_d.count = s_q.count - 16'h0001;
                end
            end
            else
            begin
                s_d.dir = WCB_DIR_UP;
                if (s_q.count == top)
                begin
                    s_d.count = `WCB_RST_WORD;
                end
                else
                begin
                    s_d.count = s_q.count + 16'h0001;
                end
                // clear-on-match modes flag at MAX, others at the ceiling
                if (ctc_mode ? (s_q.count == `WCB_MAX) : (s_q.count == top))
                begin
                    s_d.ovf = 1'b1;
                end
            end
        end
        // bus writes; the low byte commits holding byte plus data, the capture low byte only in ceiling modes
        if (I_WR)
        begin
            unique case (I_ADDR)
                `WCB_LOC_COUNT_HI, `WCB_LOC_CMPA_HI, `WCB_LOC_CMPB_HI, `WCB_LOC_CAP_HI:
                    s_d.temp = I_WDATA;
                `WCB_LOC_COUNT_LO: s_d.count = {s_q.temp, I_WDATA};
                `WCB_LOC_CMPA_LO:  s_d.cmp_a = {s_q.temp, I_WDATA};
                `WCB_LOC_CMPB_LO:  s_d.cmp_b = {s_q.temp, I_WDATA};
                `WCB_LOC_CAP_LO:
                begin
                    if (cap_is_top)
                    begin
                        s_d.cap = {s_q.temp, I_WDATA};
                    end
                end
                `WCB_LOC_CTRL_A: s_d.ctrl_a = I_WDATA;
                `WCB_LOC_CTRL_B: s_d.ctrl_b = I_WDATA;
                default: ;
            endcase
        end
        // reads answer on the next edge; unmapped locations read zero
        if (I_RD)
        begin
            unique case (I_ADDR)
                `WCB_LOC_COUNT_LO:
                begin
                    s_d.rdata = s_q.count[7:0];
                    s_d.temp  = s_q.count[15:8];
                end
                `WCB_LOC_CAP_LO:
                begin
                    s_d.rdata = s_q.cap[7:0];
                    s_d.temp  = s_q.cap[15:8];
                end
                `WCB_LOC_COUNT_HI, `WCB_LOC_CAP_HI: s_d.rdata = s_q.temp;
                `WCB_LOC_CMPA_LO: s_d.rdata = s_q.cmp_a[7:0];
                `WCB_LOC_CMPA_HI: s_d.rdata = s_q.cmp_a[15:8];
                `WCB_LOC_CMPB_LO: s_d.rdata = s_q.cmp_b[7:0];
                `WCB_LOC_CMPB_HI: s_d.rdata = s_q.cmp_b[15:8];
                `WCB_LOC_CTRL_A:  s_d.rdata = s_q.ctrl_a;
                `WCB_LOC_CTRL_B:  s_d.rdata = s_q.ctrl_b;
                default:          s_d.rdata = `WCB_RST_BYTE;
            endcase
        end
        if (s_d.ovf != s_q.ovf && s_q.ovf == 1'b0 && I_OVF_CLR)
        begin
            s_d.ovf = 1'b1; // set beats clear
        end
    end

    always_ff @(posedge I_MCLK)
    begin
        if (!I_RST_N)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign O_RDATA    = s_q.rdata;
    assign O_OVF_FLAG = s_q.ovf;
    assign O_AT_TOP   = (s_q.count == top);
    assign O_AT_FLOOR = (s_q.count == `WCB_RST_WORD);
    assign O_COUNT    = s_q.count;

    // ************************************************************
    // ** checks
    // ************************************************************
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);

    AST_LO_WRITE_COMMIT: assert property (
        wr_cnt_lo |=> O_COUNT == {$past(s_q.temp), $past(I_WDATA)})
        else $error("count low write did not commit holding byte and data");
    AST_LO_READ_LATCH: assert property (
        I_RD && !I_WR && I_ADDR == `WCB_LOC_COUNT_LO |=> s_q.temp == $past(O_COUNT[15:8]))
        else $error("count low read did not latch high half");
    AST_LO_READ_DATA: assert property (
        I_RD && I_ADDR == `WCB_LOC_COUNT_LO |=> O_RDATA == $past(O_COUNT[7:0]))
        else $error("count low read returned wrong byte");
    AST_CMP_NO_TEMP: assert property (
        I_RD && !I_WR && (I_ADDR >= `WCB_LOC_CMPA_LO) && (I_ADDR <= `WCB_LOC_CMPB_HI)
        |=> $stable(s_q.temp))
        else $error("compare read disturbed holding byte");
    AST_HI_READ_TEMP: assert property (
        I_RD && I_ADDR == `WCB_LOC_COUNT_HI |=> O_RDATA == $past(s_q.temp))
        else $error("count high read bypassed holding byte");
    AST_STOPPED: assert property (
        csel == 3'h0 && !I_WR ##1 csel == 3'h0 && !I_WR |-> $stable(O_COUNT))
        else $error("counter moved with no tick source");
    AST_HI_WRITE_TEMP: assert property (
        I_WR && I_ADDR == `WCB_LOC_COUNT_HI && !I_RD |=> s_q.temp == $past(I_WDATA)
        && ($stable(O_COUNT[15:8]) || $past(tick)))
        else $error("high write missed holding byte");
    AST_CAP_GATED: assert property (
        I_WR && I_ADDR == `WCB_LOC_CAP_LO && !cap_is_top && !I_CAPTURE |=> $stable(s_q.cap))
        else $error("capture value written outside ceiling mode");
    AST_OVF_STICKY: assert property (
        O_OVF_FLAG && !I_OVF_CLR |=> O_OVF_FLAG)
        else $error("overflow flag dropped without clear");

    COV_COUNT_WRITE:  cover property (I_WR && I_ADDR == `WCB_LOC_COUNT_HI ##1 wr_cnt_lo);
    COV_COUNT_READ:   cover property (I_RD && I_ADDR == `WCB_LOC_COUNT_LO
                                      ##1 I_RD && I_ADDR == `WCB_LOC_COUNT_HI);
    COV_OVERFLOW:     cover property (!O_OVF_FLAG ##1 O_OVF_FLAG);
    COV_WRITE_VS_TICK: cover property (wr_cnt_lo && tick);
endmodule // wcb_timer

// File: tb/wcb_cpu_model.sv
`timescale 1ns/100ps
module wcb_cpu_model
(
    // clock
    input  wire logic       i_clk,
    // byte bus
    output logic      [3:0] o_addr,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_wdata,
    input  wire logic [7:0] i_rdata
);
    initial
    begin
        o_addr  = 4'hF;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 8'h00;
    end
    // released data lines show the inverse so stale bytes never look valid
    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
    endtask
    task automatic rd8(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        @(posedge i_clk);
        d = i_rdata;
    endtask
    // two byte accesses, never interleaved with any other access
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        wr8(lo + 4'h1, v[15:8]);
        wr8(lo, v[7:0]);
    endtask
    task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
        rd8(lo, v[7:0]);
        rd8(lo + 4'h1, v[15:8]);
    endtask
endmodule // wcb_cpu_model

// File: tb/tb_top.sv
`timescale 1ns/100ps
`include "wcb_defs.svh"
module tb_top;
    import wcb_pkg::*;
    logic        clk, rst_n, wr, rd, ext, cap, oclr, ovf, top, flr;
    logic [3:0]  addr;
    logic [7:0]  wd, rdat, b;
    logic [15:0] cnt, w;
    int          n_mismatch, cmp_count;
    wcb_timer uut (.I_MCLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
        .I_WDATA(wd), .O_RDATA(rdat), .I_EXT_TICK(ext), .I_CAPTURE(cap), .I_OVF_CLR(oclr),
        .O_OVF_FLAG(ovf), .O_AT_TOP(top), .O_AT_FLOOR(flr), .O_COUNT(cnt));
    wcb_cpu_model cpu (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wd),
        .i_rdata(rdat));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // bounded wait on the ceiling or the overflow flag
    task automatic wait_for(input bit use_ovf);
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk);
            #1;
            if (use_ovf ? ovf === 1'b1 : top === 1'b1)
                return;
        end
        n_mismatch++;
        $display("MISMATCH wait expected 1 seen 0");
        end_sim();
    endtask
    task automatic pulse(input bit which);
        @(posedge clk);
        if (which)
        begin
            cap <= 1'b1;
        end
        else
        begin
            oclr <= 1'b1;
        end
        @(posedge clk);
        cap  <= 1'b0;
        oclr <= 1'b0;
        #1;
    endtask
    initial
    begin
        rst_n = 1'b0;
        ext = 1'b0;
        cap = 1'b0;
        oclr = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("reset count", 16'h0000, cnt);
        chk("reset floor", 16'h0001, {15'h0000, flr});
        chk("reset ovf", 16'h0000, {15'h0000, ovf});
        cpu.wr16(`WCB_LOC_COUNT_LO, 16'h01FF);
        #1;
        chk("count write", 16'h01FF, cnt);
        repeat (5) @(posedge clk);
        #1;
        chk("count stopped", 16'h01FF, cnt);
        cpu.rd16(`WCB_LOC_COUNT_LO, w);
        chk("count read", 16'h01FF, w);
        cpu.wr8(`WCB_LOC_COUNT_HI, 8'hAB);
        cpu.rd8(`WCB_LOC_COUNT_HI, b);
        chk("count hi holding", 16'h00AB, {8'h00, b});
        chk("count hi untouched", 16'h01FF, cnt);
        cpu.wr16(`WCB_LOC_CMPA_LO, 16'h1234);
        cpu.wr8(`WCB_LOC_COUNT_HI, 8'h77);
        cpu.rd8(`WCB_LOC_CMPA_HI, b);
        chk("cmp direct hi", 16'h0012, {8'h00, b});
        cpu.rd8(`WCB_LOC_COUNT_HI, b);
        chk("holding kept", 16'h0077, {8'h00, b});
        cpu.wr8(`WCB_LOC_COUNT_HI, 8'h3C);
        cpu.wr8(`WCB_LOC_CMPA_LO, 8'h01);
        cpu.wr8(`WCB_LOC_CMPB_LO, 8'h02);
        cpu.rd16(`WCB_LOC_CMPA_LO, w);
        chk("shared hi a", 16'h3C01, w);
        cpu.rd16(`WCB_LOC_CMPB_LO, w);
        chk("shared hi b", 16'h3C02, w);
        pulse(1'b1);
        cpu.rd16(`WCB_LOC_CAP_LO, w);
        chk("capture read", 16'h01FF, w);
        cpu.wr16(`WCB_LOC_CAP_LO, 16'h4444);
        cpu.rd16(`WCB_LOC_CAP_LO, w);
        chk("capture locked", 16'h01FF, w);
        cpu.wr8(`WCB_LOC_CTRL_B, 8'h18);
        cpu.wr16(`WCB_LOC_CAP_LO, 16'h0010);
        cpu.rd16(`WCB_LOC_CAP_LO, w);
        chk("capture ceiling", 16'h0010, w);
        // normal mode up count through the wrap
        cpu.wr8(`WCB_LOC_CTRL_B, 8'h00);
        cpu.wr16(`WCB_LOC_COUNT_LO, 16'hFFF0);
        cpu.wr8(`WCB_LOC_CTRL_B, 8'h01);
        wait_for(1'b0);
        chk("top at max", 16'hFFFF, cnt);
        wait_for(1'b1);
        chk("ovf after wrap", 16'h0001, {15'h0000, ovf});
        pulse(1'b0);
        chk("ovf cleared", 16'h0000, {15'h0000, ovf});
        cpu.wr16(`WCB_LOC_COUNT_LO, 16'h1000);
        #1;
        chk("write beats tick", 16'h1000, cnt);
        // dual slope with fixed 8-bit ceiling
        cpu.wr8(`WCB_LOC_CTRL_B, 8'h00);
        cpu.wr8(`WCB_LOC_CTRL_A, 8'h01);
        cpu.wr16(`WCB_LOC_COUNT_LO, 16'h00F8);
        cpu.wr8(`WCB_LOC_CTRL_B, 8'h01);
        wait_for(1'b0);
        chk("dual top", 16'h00FF, cnt);
        repeat (2) @(posedge clk);
        #1;
        chk("down count", 16'h00FD, cnt);
        // clear on match with compare A ceiling
        cpu.wr8(`WCB_LOC_CTRL_B, 8'h00);
        cpu.wr8(`WCB_LOC_CTRL_A, 8'h00);
        cpu.wr16(`WCB_LOC_CMPA_LO, 16'h0005);
        cpu.wr16(`WCB_LOC_COUNT_LO, 16'h0000);
        cpu.wr8(`WCB_LOC_CTRL_B, 8'h09);
        wait_for(1'b0);
        chk("ctc top", 16'h0005, cnt);
        @(posedge clk);
        #1;
        chk("ctc clear", 16'h0000, cnt);
        chk("floor seen", 16'h0001, {15'h0000, flr});
        // prescaled tick: any 80 clocks hold exactly ten divide-by-8 ticks
        cpu.wr8(`WCB_LOC_CTRL_B, 8'h00);
        cpu.wr16(`WCB_LOC_COUNT_LO, 16'h0000);
        cpu.wr8(`WCB_LOC_CTRL_B, 8'h02);
        repeat (80) @(posedge clk);
        #1;
        chk("prescaled ticks", 16'h000A, cnt);
        // external falling edges first, then rising edges
        for (int m = 0; m < 2; m++)
        begin
            cpu.wr8(`WCB_LOC_CTRL_B, 8'h00);
            cpu.wr16(`WCB_LOC_COUNT_LO, 16'h0000);
            cpu.wr8(`WCB_LOC_CTRL_B, m ? 8'h07 : 8'h06);
            repeat (3)
            begin
                repeat (4) @(posedge clk);
                ext <= 1'b1;
                repeat (4) @(posedge clk);
                ext <= 1'b0;
            end
            repeat (6) @(posedge clk);
            #1;
            chk("ext ticks", 16'h0003, cnt);
        end
        // reset again in mid-run: everything returns to its idle values
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("mid reset count", 16'h0000, cnt);
        chk("mid reset floor", 16'h0001, {15'h0000, flr});
        cpu.rd8(`WCB_LOC_CTRL_B, b);
        chk("mid reset select", 16'h0000, {8'h00, b});
        end_sim();
    end
endmodule // tb_top
